// >>> rtl/nvm_device.sv
// nonvolatile data store with index, value and control registers
// assumes the core writes through the port in nvm_if; control sits behind the pointer
// Operation
// - sixty-four bytes reached only through registers
// - six-bit index, upper two bits read zero
// - value register holds last fetched byte
// - index and value directly reachable in sector0
// - control at 40H sector 1, indirect
// - control bits 3..0, upper read zero
// - fetch go needs fetch enable first
// - fetch go clears when read ends
// - software sets enable and index first
// - program go needs program enable first
// - write timed by separate timer, then clears
// - enable then go in next instruction
// - software masks interrupts around write start
// - never both go bits together
// - enables low block every operation
// - reset clears enable and pointers
// - write end sets both request flags
// - vector needs all enables, stack not full
// - service clears multi-function flag only; nvm_core also pulses nvm_irq_flag_clr on a vector, so both flags clear
// - no sleep during a cycle
`timescale 1ns/100ps
module nvm_device import nvm_pkg::*; (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	nvm_if.device bus, // register port
	output logic busy // a cycle is in progress
);
	typedef enum logic [1:0] {IDLE, READING, WRITING} state_e;

	// storage array, not mapped into data memory
	logic [BYTE_W-1:0] mem_q [NVM_DEPTH];
	logic [IDX_W-1:0] index_q, index_d; // byte index
	logic [BYTE_W-1:0] value_q, value_d; // data register
	logic [3:0] ctrl_q, ctrl_d; // control bits
	logic [7:0] plow_q, plow_d; // pointer low byte
	logic [7:0] phigh_q, phigh_d; // pointer high byte
	state_e st_q, st_d; // cycle state
	logic [CNT_W-1:0] cnt_q, cnt_d; // cycle counter
	logic flag_q, flag_d; // write-done flag
	logic mf_q, mf_d; // multi-function flag
	logic mem_we; // commit byte to array
	logic wtick; // write timer pulse
	logic ctrl_hit; // pointer selects control register
	logic ctrl_wr; // write to control this cycle

	// the write timer runs off its own divided rate, not the core's instruction rate
	tick_div #(.DIV(WTIMER_DIV)) u_wtimer (
		.clk(clk),
		.resetn(resetn),
		.tick(wtick)
	);

	// control reachable only via pointer 40H / 01H
	assign ctrl_hit = (plow_q == CTRL_OFFSET) && (phigh_q == CTRL_SECTOR);
	assign ctrl_wr = bus.wr && (bus.sel == SEL_IND) && ctrl_hit;
	assign busy = (st_q != IDLE);

	// read mux: unimplemented bits read zero
	always_comb begin
		bus.rdata = RESET_BYTE;
		case (bus.sel)
			SEL_INDEX: bus.rdata = {2'b00, index_q};
			SEL_VALUE: bus.rdata = value_q;
			SEL_PTR: bus.rdata = plow_q;
			SEL_IND: bus.rdata = ctrl_hit ? {4'h0, ctrl_q} : RESET_BYTE;
			default: bus.rdata = RESET_BYTE;
		endcase
	end
	assign bus.nvm_irq_flag = flag_q;
	assign bus.mf_irq_flag = mf_q;

	// next-state for registers, cycle engine and flags
	always_comb begin
		logic [3:0] req;
		logic rgo, wgo;
		req = bus.wdata[3:0];
		rgo = 1'b0;
		wgo = 1'b0;
		index_d = index_q;
		value_d = value_q;
		ctrl_d = ctrl_q;
		plow_d = plow_q;
		phigh_d = phigh_q;
		st_d = st_q;
		cnt_d = cnt_q;
		flag_d = flag_q;
		mf_d = mf_q;
		mem_we = 1'b0;
		if (bus.wr) begin
			case (bus.sel)
				// direct writes to index and value
				SEL_INDEX: index_d = bus.wdata[IDX_W-1:0];
				SEL_VALUE: value_d = bus.wdata;
				// pointer writes: rd picks the high byte, a small port economy
				SEL_PTR: begin
					if (bus.rd) begin
						phigh_d = bus.wdata;
					end else begin
						plow_d = bus.wdata;
					end
				end
				default: ;
			endcase
		end
		if (ctrl_wr) begin
			// enables are plain storage; go bits only start when idle
			ctrl_d[BIT_PROGRAM_ENABLE] = req[BIT_PROGRAM_ENABLE];
			ctrl_d[BIT_FETCH_ENABLE] = req[BIT_FETCH_ENABLE];
			// fetch go gated by enable already high
			rgo = req[BIT_RGO] && !ctrl_q[BIT_RGO] && ctrl_q[BIT_FETCH_ENABLE];
			// program go gated by enable already high
			wgo = req[BIT_WGO] && !ctrl_q[BIT_WGO] && ctrl_q[BIT_PROGRAM_ENABLE];
			// both go bits at once: ignore both
			if (req[BIT_RGO] && req[BIT_WGO]) begin
				rgo = 1'b0;
				wgo = 1'b0;
			end
			if (st_q == IDLE && rgo) begin
				ctrl_d[BIT_RGO] = 1'b1;
				st_d = READING;
				cnt_d = CNT_W'(READ_CYCLES - 1);
			end else if (st_q == IDLE && wgo) begin
				ctrl_d[BIT_WGO] = 1'b1;
				st_d = WRITING;
				cnt_d = CNT_W'(WRITE_TICKS - 1);
			end
		end
		// software clears write-done; the set below wins
		if (bus.nvm_irq_flag_clr) begin
			flag_d = 1'b0;
		end
		// vector service clears only the multi-function flag
		if (bus.irq_ack) begin
			mf_d = 1'b0;
		end
		case (st_q)
			IDLE: ;
			READING: begin
				if (cnt_q == '0) begin
					// load byte and clear fetch go in the same cycle
					value_d = mem_q[index_q];
					ctrl_d[BIT_RGO] = 1'b0;
					st_d = IDLE;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			WRITING: begin
				// counted on the write timer pulses
				if (wtick) begin
					if (cnt_q == '0) begin
						mem_we = 1'b1;
						ctrl_d[BIT_WGO] = 1'b0;
						st_d = IDLE;
						flag_d = 1'b1;
						mf_d = 1'b1;
					end else begin
						cnt_d = cnt_q - CNT_W'(1);
					end
				end
			end
			default: st_d = IDLE;
		endcase
	end

	// reset clears enables, pointers and registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			index_q <= '0;
			value_q <= RESET_BYTE;
			ctrl_q <= CTRL_RESET;
			plow_q <= SECTOR0;
			phigh_q <= SECTOR0;
			st_q <= IDLE;
			cnt_q <= '0;
			flag_q <= 1'b0;
			mf_q <= 1'b0;
		end else begin
			index_q <= index_d;
			value_q <= value_d;
			ctrl_q <= ctrl_d;
			plow_q <= plow_d;
			phigh_q <= phigh_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			flag_q <= flag_d;
			mf_q <= mf_d;
		end
	end

	// array written only at the end of the timed cycle
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem_q[index_q] <= value_q;
		end
	end
endmodule

// >>> rtl/nvm_pkg.sv
// shared constants for the data nonvolatile store and its core-side driver
// assumes one 10 MHz system clock and an asynchronous active-low reset
package nvm_pkg;
	localparam int NVM_DEPTH = 64;
	localparam int IDX_W = 6;
	localparam int BYTE_W = 8;
	localparam logic [7:0] CTRL_OFFSET = 8'h40;
	localparam logic [7:0] CTRL_SECTOR = 8'h01;
	localparam logic [7:0] SECTOR0 = 8'h00;
	localparam int BIT_RGO = 0;
	localparam int BIT_FETCH_ENABLE = 1;
	localparam int BIT_WGO = 2;
	localparam int BIT_PROGRAM_ENABLE = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int READ_CYCLES = 4;
	localparam int WRITE_TICKS = 16;
	localparam int WTIMER_DIV = 8;
	localparam int CNT_W = 16;
	// register selects on the special function register port
	localparam logic [1:0] SEL_INDEX = 2'h0;
	localparam logic [1:0] SEL_VALUE = 2'h1;
	localparam logic [1:0] SEL_PTR = 2'h2;
	localparam logic [1:0] SEL_IND = 2'h3;
endpackage

// >>> rtl/nvm_if.sv
// special function register port between the core and the nvm block
// assumes both ends share clk; the core end drives requests, the device answers
`timescale 1ns/100ps
interface nvm_if;
	logic wr; // write strobe, one cycle
	logic rd; // picks the pointer high byte on a pointer write
	logic [1:0] sel; // register select
	logic [7:0] wdata; // write byte
	logic [7:0] rdata; // read byte
	logic irq_ack; // interrupt vector taken, one cycle
	logic nvm_irq_flag_clr; // software clears write-done flag
	logic nvm_irq_flag; // write-done request flag
	logic mf_irq_flag; // multi-function request flag
	modport device (input wr, rd, sel, wdata, irq_ack, nvm_irq_flag_clr,
		output rdata, nvm_irq_flag, mf_irq_flag);
	modport core (output wr, rd, sel, wdata, irq_ack, nvm_irq_flag_clr,
		input rdata, nvm_irq_flag, mf_irq_flag);
endinterface

// >>> rtl/tick_div.sv
// divider giving a one-cycle enable pulse every DIV clocks
// assumes free-running clk; stands in for the independent write timer clock
`timescale 1ns/100ps
module tick_div #(parameter int DIV = 8) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	output logic tick // one-cycle enable
);
	logic [15:0] cnt_q, cnt_d; // down counter

	// count down and reload
	always_comb begin
		tick = (cnt_q == 16'h0000);
		cnt_d = tick ? 16'(DIV - 1) : cnt_q - 16'h0001;
	end

	// register the counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// >>> rtl/nvm_core.sv
// core-side sequencer that performs one read or write of the nvm store
// assumes the device end on nvm_if and one instruction per clock
`timescale 1ns/100ps
module nvm_core import nvm_pkg::*; (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	nvm_if.core bus, // register port
	input wire logic start, // begin an operation, pulse
	input wire logic is_write, // 1 write, 0 read
	input wire logic [5:0] addr, // byte index
	input wire logic [7:0] wdata, // byte to write
	input wire logic global_irq_enable, // core global enable
	input wire logic nvm_irq_enable, // nvm interrupt enable
	input wire logic mf_irq_enable, // multi-function enable
	input wire logic stack_full, // return stack full
	output logic irq_take, // vector taken, pulse
	output logic done, // operation finished, pulse
	output logic [7:0] rdata, // byte read
	output logic irq_mask // global enable held off
);
	typedef enum logic [3:0] {S_IDLE, S_ADDR, S_DATA, S_PL, S_PH, S_EN, S_GO, S_POLL,
		S_CLR, S_PH0, S_FETCH} state_e;
	state_e st_q, st_d; // sequence step
	logic wr_q, wr_d; // latched direction
	logic [7:0] rd_q, rd_d; // read result
	logic mask_q, mask_d; // interrupts held off

	// vector only with all enables and room on the stack
	assign irq_take = bus.mf_irq_flag && global_irq_enable && !mask_q && nvm_irq_enable
		&& mf_irq_enable && !stack_full;
	assign bus.irq_ack = irq_take;
	assign bus.nvm_irq_flag_clr = irq_take;
	assign rdata = rd_q;
	assign irq_mask = mask_q;

	// one register access per step
	always_comb begin
		st_d = st_q;
		wr_d = wr_q;
		rd_d = rd_q;
		mask_d = mask_q;
		done = 1'b0;
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		bus.sel = SEL_INDEX;
		bus.wdata = RESET_BYTE;
		case (st_q)
			S_IDLE: if (start) begin
				wr_d = is_write;
				st_d = S_ADDR;
			end
			// index, plus data for a write, loaded before enabling
			S_ADDR: begin
				bus.wr = 1'b1;
				bus.wdata = {2'b00, addr};
				st_d = wr_q ? S_DATA : S_PL;
			end
			S_DATA: begin
				bus.wr = 1'b1;
				bus.sel = SEL_VALUE;
				bus.wdata = wdata;
				st_d = S_PL;
			end
			S_PL: begin
				bus.wr = 1'b1;
				bus.sel = SEL_PTR;
				bus.wdata = CTRL_OFFSET;
				st_d = S_PH;
			end
			S_PH: begin
				bus.wr = 1'b1;
				bus.rd = 1'b1;
				bus.sel = SEL_PTR;
				bus.wdata = CTRL_SECTOR;
				// hold interrupts off over the write start
				mask_d = wr_q;
				st_d = S_EN;
			end
			// enable alone first, never both go bits
			S_EN: begin
				bus.wr = 1'b1;
				bus.sel = SEL_IND;
				bus.wdata = 8'(1 << (wr_q ? BIT_PROGRAM_ENABLE : BIT_FETCH_ENABLE));
				st_d = S_GO;
			end
			S_GO: begin
				bus.wr = 1'b1;
				bus.sel = SEL_IND;
				bus.wdata = wr_q ? 8'(1 << BIT_PROGRAM_ENABLE | 1 << BIT_WGO)
					: 8'(1 << BIT_FETCH_ENABLE | 1 << BIT_RGO);
				st_d = S_POLL;
			end
			// restore interrupts once the cycle runs; poll go bit
			S_POLL: begin
				mask_d = 1'b0;
				bus.sel = SEL_IND;
				if (bus.rdata[wr_q ? BIT_WGO : BIT_RGO] == 1'b0) begin
					st_d = S_CLR;
				end
			end
			S_CLR: begin
				bus.wr = 1'b1;
				bus.sel = SEL_IND;
				st_d = S_PH0;
			end
			// park the pointer back in sector 0 for protection
			S_PH0: begin
				bus.wr = 1'b1;
				bus.rd = 1'b1;
				bus.sel = SEL_PTR;
				bus.wdata = SECTOR0;
				st_d = S_FETCH;
			end
			S_FETCH: begin
				bus.sel = SEL_VALUE;
				rd_d = bus.rdata;
				done = 1'b1;
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// register the sequence state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= S_IDLE;
			wr_q <= 1'b0;
			rd_q <= RESET_BYTE;
			mask_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			mask_q <= mask_d;
		end
	end
endmodule

// >>> test/nvm_assertions.sv
// checker for the register port joining core and device
// assumes the plain nets of nvm_if and the one system clock
`timescale 1ns/100ps
module nvm_assertions import nvm_pkg::*; (
	input wire logic clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic wr, // write strobe
	input wire logic rd, // pointer high select
	input wire logic [1:0] sel, // register select
	input wire logic [7:0] wdata, // write byte
	input wire logic [7:0] rdata, // read byte
	input wire logic irq_ack, // vector taken
	input wire logic nvm_irq_flag_clr, // flag clear
	input wire logic nvm_irq_flag, // write-done flag
	input wire logic mf_irq_flag // shared flag
);
	// slack of one timer tick either side, the timer phase is free
	localparam int WLO = (WRITE_TICKS - 1) * WTIMER_DIV;
	localparam int WHI = (WRITE_TICKS + 1) * WTIMER_DIV + 2;
	logic [7:0] plo_q; // pointer low shadow
	logic [7:0] phi_q; // pointer high shadow
	logic [15:0] wcnt_q; // cycles since write go
	wire ctl = sel == SEL_IND && phi_q == CTRL_SECTOR && plo_q == CTRL_OFFSET;
	// shadow the pointer and time the write cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			plo_q <= 8'h00;
			phi_q <= 8'h00;
			wcnt_q <= 16'h0000;
		end else begin
			if (wr && sel == SEL_PTR && !rd)
				plo_q <= wdata;
			if (wr && sel == SEL_PTR && rd)
				phi_q <= wdata;
			if (wr && ctl && wdata[BIT_WGO])
				wcnt_q <= 16'h0000;
			else if (wcnt_q != 16'hffff)
				wcnt_q <= wcnt_q + 16'h0001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_pair; $rose(nvm_irq_flag) |-> mf_irq_flag; endproperty
	a_pair: assert property (p_pair) else $error("flags not raised together");
	property p_ack; irq_ack |=> !mf_irq_flag; endproperty
	a_ack: assert property (p_ack) else $error("shared flag kept");
	property p_keep;
		nvm_irq_flag && !nvm_irq_flag_clr |=> nvm_irq_flag;
	endproperty
	a_keep: assert property (p_keep) else $error("done flag lost");
	property p_clr; nvm_irq_flag_clr |=> !nvm_irq_flag; endproperty
	a_clr: assert property (p_clr) else $error("done flag not cleared");
	property p_idx; sel == SEL_INDEX |-> rdata[7:6] == 2'h0; endproperty
	a_idx: assert property (p_idx) else $error("index upper bits set");
	property p_ctl; ctl |-> rdata[7:4] == 4'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("control upper bits set");
	property p_rtime;
		wr && ctl && wdata == 8'h03 |=> (!ctl || rdata[BIT_RGO]) [*4] ##1 (!ctl || !rdata[BIT_RGO]);
	endproperty
	a_rtime: assert property (p_rtime) else $error("read go timing");
	property p_wtime; $rose(nvm_irq_flag) |-> wcnt_q >= WLO && wcnt_q <= WHI; endproperty
	a_wtime: assert property (p_wtime) else $error("write end timing");
	property p_wgo; ctl && $past(ctl) && $fell(rdata[BIT_WGO]) |-> wcnt_q >= WLO; endproperty
	a_wgo: assert property (p_wgo) else $error("write go cleared early");
	c_read: cover property (wr && ctl && wdata == 8'h03);
	c_write: cover property ($rose(nvm_irq_flag));
	c_ack: cover property (irq_ack);
endmodule

// >>> test/testbench.sv
// bench: core and device joined, plus a second device driven by hand
// assumes nvm_pkg constants and a 10 MHz clock
`timescale 1ns/100ps
module testbench import nvm_pkg::*;;
	typedef struct packed {logic [7:0] b; logic [1:0] t;} note_s;
	logic clk = 0;
	logic resetn = 0;
	logic start = 0;
	logic is_write = 0;
	logic gie = 0;
	logic nie = 0;
	logic mie = 0;
	logic sfull = 0;
	logic [5:0] addr = 0;
	logic [7:0] wd = 0;
	logic irq_take, done, irq_mask, busy, busy2, late = 0;
	logic [7:0] rdata;
	logic [7:0] mem_m [64]; // expected array contents
	logic [31:0] seed = 77558;
	note_s q [$]; // expected results, oldest first
	note_s cur;
	bit pend = 0; // done flag still waiting for a vector
	int errors = 0, n_checks = 0, cyc = 0, takes = 0;
	nvm_if bus();
	nvm_if bus2(); // hand-driven port for misuse
	nvm_device nvm_device_i(.clk, .resetn, .bus(bus), .busy(busy));
	nvm_core nvm_core_i(.clk, .resetn, .bus(bus), .start, .is_write, .addr, .wdata(wd),
		.global_irq_enable(gie), .nvm_irq_enable(nie), .mf_irq_enable(mie),
		.stack_full(sfull), .irq_take, .done, .rdata, .irq_mask);
	if (1) begin : bad
		nvm_device nvm_device_i(.clk, .resetn, .bus(bus2), .busy(busy2));
	end
	nvm_assertions nvm_assertions_i(.clk, .resetn, .wr(bus.wr), .rd(bus.rd), .sel(bus.sel),
		.wdata(bus.wdata), .rdata(bus.rdata), .irq_ack(bus.irq_ack),
		.nvm_irq_flag_clr(bus.nvm_irq_flag_clr), .nvm_irq_flag(bus.nvm_irq_flag),
		.mf_irq_flag(bus.mf_irq_flag));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task stop_test;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one register access on the hand-driven port, held over one edge
	task w2(input logic [1:0] s, input logic r, input logic [7:0] d);
		@(posedge clk);
		#1 {bus2.wr, bus2.rd, bus2.sel, bus2.wdata} = {1'b1, r, s, d};
		@(posedge clk);
		#1 bus2.wr = 0;
	endtask
	// read back a register; no cycle may have started
	task r2(input logic [1:0] s, input logic [7:0] e);
		@(posedge clk);
		#1 bus2.sel = s;
		#1 chk8(bus2.rdata, e);
		chk1(busy2, 1'b0);
	endtask
	// one core operation; the note is taken before the start pulse
	task op(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 gie = seed[0] | seed[1];
		nie = seed[4] | seed[5];
		mie = 1;
		sfull = seed[2] & seed[3];
		// a pending flag is taken at once when enabled, this write's own flag at its end
		if (gie & nie & mie & !sfull) begin
			cur.t = 2'(pend) + 2'(w);
			pend = 0;
		end else begin
			cur.t = 2'h0;
			pend = pend | w;
		end
		cur.b = w ? d : mem_m[a];
		if (w)
			mem_m[a] = d;
		q.push_back(cur);
		{start, is_write, addr, wd} = {1'b1, w, a, d};
		@(posedge clk);
		#1 start = 0;
		repeat (400) begin
			@(posedge clk);
			#1;
			if (done === 1)
				break;
		end
	endtask
	// results: vector count at done, held byte one cycle later
	always @(posedge clk) begin
		note_s n;
		#2;
		if (late)
			chk8(rdata, n.b);
		late = 0;
		if (irq_take === 1)
			takes++;
		// interrupts held off only around a write go
		if (bus.wr === 1 && bus.sel === SEL_IND && bus.wdata[BIT_WGO] === 1)
			chk1(irq_mask, 1'b1);
		if (bus.wr === 1 && bus.sel === SEL_IND && bus.wdata[BIT_RGO] === 1)
			chk1(irq_mask, 1'b0);
		if (done === 1) begin
			n = q.pop_front();
			chk8(takes[7:0], {6'h00, n.t});
			chk1(busy, 1'b0);
			takes = 0;
			late = 1;
		end
	end
	// hang guard well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		{bus2.wr, bus2.rd, bus2.sel, bus2.wdata, bus2.irq_ack, bus2.nvm_irq_flag_clr} = 0;
		repeat (12) @(posedge clk);
		#1 resetn = 1;
		r2(SEL_INDEX, 8'h00);
		r2(SEL_VALUE, 8'h00);
		w2(SEL_PTR, 0, CTRL_OFFSET);
		w2(SEL_PTR, 1, CTRL_SECTOR);
		r2(SEL_IND, 8'h00);
		w2(SEL_IND, 0, 8'h01);
		r2(SEL_IND, 8'h00);
		w2(SEL_IND, 0, 8'h04);
		r2(SEL_IND, 8'h00);
		w2(SEL_IND, 0, 8'h0a);
		w2(SEL_IND, 0, 8'hff);
		r2(SEL_IND, 8'h0a);
		r2(SEL_VALUE, 8'h00);
		w2(SEL_PTR, 1, SECTOR0);
		w2(SEL_IND, 0, 8'h00);
		w2(SEL_PTR, 1, CTRL_SECTOR);
		r2(SEL_IND, 8'h0a);
		w2(SEL_INDEX, 0, 8'hff);
		r2(SEL_INDEX, 8'h3f);
		// fill every byte, then mix random reads and writes
		for (int i = 0; i < 104; i++) begin
			seed = nx(seed);
			op(i < 64 ? 1'b1 : seed[8], i < 64 ? i[5:0] : seed[14:9], seed[7:0]);
		end
		repeat (3) @(posedge clk);
		chk8(8'(q.size()), 8'h00);
		stop_test();
	end
endmodule
